/* File: hw/vhp_pkg.sv */
// Constants and types for the video host port slave.
// Assumes a host master that frames each byte over four link clocks, MSB pair first.
package vhp_pkg;

	// Strap pattern {genlock, line standard, field id}; 0 pulldown, 1 pullup
	localparam logic [2:0] VHP_STRAP_HOST = 3'h2;

	// Command byte fields
	localparam logic [1:0] VHP_DEVSEL      = 2'h1;
	localparam int         VHP_CMD_SEL_HI  = 7;
	localparam int         VHP_CMD_SEL_LO  = 6;
	localparam int         VHP_CMD_RD      = 5;
	localparam int         VHP_CMD_FIFO    = 4;
	localparam int         VHP_CMD_AHI_HI  = 3;
	localparam int         VHP_CMD_AHI_LO  = 0;

	// Phase timing in link clocks
	localparam logic [1:0] VHP_PHASE_LAST  = 2'h3;
	localparam logic [1:0] VHP_CYC_STOP    = 2'h0;
	localparam logic [1:0] VHP_CYC_ACK     = 2'h1;

	// Reset values
	localparam logic [7:0] VHP_BYTE_RST    = 8'h00;
	localparam logic [5:0] VHP_SHIFT_RST   = 6'h00;

	typedef struct packed {
		logic        rd;
		logic        fifo;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} vhp_req_t;

	typedef enum logic [3:0] {
		VHP_IDLE,
		VHP_CMD,
		VHP_ADDR,
		VHP_DECODE,
		VHP_RETRY,
		VHP_WAIT,
		VHP_DATA,
		VHP_TA,
		VHP_SKIP
	} vhp_state_t;

endpackage

/* File: hw/vhp_top.sv */
// Video host port slave: link sequencer on the host clock, straps, request crossing and interrupt pin.
// Assumes the system side answers every request with one rsp_valid_in pulse, reads and writes alike.
//
// Operation
// - Port enabled only for straps 0,1,0.
// - Command, address, data share two-wire bus.
// - Slave drives control only to stop or ack.
// - Interrupt pin open drain, push-pull by setting.
// - Outputs high impedance until host enables driving.
// - Command phase carries eight-bit command byte.
// - Register transfers add low address byte.
// - One-clock decode phase follows command/address.
// - Four-clock retry phase: stop, wait, or data.
// - Stop in retry ends transfer without data.
// - Control low in second cycle means ready.
// - Bus owner keeps driving during wait phase.
// - Reads wait until data returns; writes wait once.
// - Acknowledge in cycle one leads to data.
// - One turnaround cycle after reads releases bus.
// - Command byte: select 01, read, FIFO, address.
// - Exactly one wait before write data.
// - Pending write terminates new accesses.
`timescale 1ns/100ps

module vhp_top
	import vhp_pkg::*;
(
	// System clock and reset
	input  wire logic     clk_in,
	input  wire logic     nrst_in,
	// Straps and host enable
	input  wire logic     genlock_strap_in,
	input  wire logic     line_standard_strap_in,
	input  wire logic     field_id_strap_in,
	input  wire logic     drive_enable_in,
	output logic          port_enabled_out,
	// Host link
	input  wire logic     host_clock_pin_in,
	input  wire logic     host_bus_bit0_in,
	input  wire logic     host_bus_bit1_in,
	output logic          host_bus_bit0_out,
	output logic          host_bus_bit1_out,
	output logic          host_bus_oe_out,
	input  wire logic     host_control_pin_in,
	output logic          host_control_pin_out,
	output logic          host_control_pin_oe_out,
	// Requests to the register and FIFO logic
	output logic          req_valid_out,
	output vhp_req_t      req_out,
	input  wire logic     rsp_valid_in,
	input  wire logic [7:0] rsp_rdata_in,
	// Interrupt
	input  wire logic     irq_in,
	input  wire logic     irq_push_pull_in,
	output logic          interrupt_request_pin_out,
	output logic          interrupt_request_pin_oe_out
);

	// System domain
	logic [3:0] pin_s1_ff;
	logic [3:0] pin_s2_ff;
	logic [3:0] pin_s3_ff;
	logic [3:0] pin_lvl_ff;
	logic       port_en_ff;
	logic       req_s1_ff;
	logic       req_s2_ff;
	logic       req_seen_ff;
	logic       busy_ff;
	logic       ack_tgl_ff;
	logic [7:0] rdata_ff;
	logic       req_valid_ff;
	vhp_req_t   req_ff;
	logic       int_out_ff;
	logic       int_oe_ff;
	logic       req_evt;

	// Link domain
	logic       go_s1_ff;
	logic       go_s2_ff;
	logic       ack_s1_ff;
	logic       ack_s2_ff;
	logic       ack_seen_ff;
	vhp_state_t st_ff;
	logic [1:0] cnt_ff;
	logic [5:0] sh_ff;
	logic [7:0] cmd_ff;
	logic [7:0] addr_lo_ff;
	logic       stop_ff;
	logic       acked_ff;
	logic       bus0_ff;
	logic       bus1_ff;
	logic       bus_oe_ff;
	logic       ctl_oe_ff;
	logic       req_tgl_ff;
	vhp_req_t   hold_ff;
	logic       wr_pend_ff;
	logic       rd_rdy_ff;
	logic [1:0] bus_in;
	logic [7:0] byte_in;
	logic       is_rd;
	logic       ack_ok;
	logic       launch_rd;
	logic       launch_wr;
	logic       ack_evt;

	function automatic logic [1:0] pair_of(input logic [7:0] b, input logic [1:0] idx);
		pair_of = b[{~idx, 1'b1} -: 2];
	endfunction

	// Pin synchronisers; a level counts once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pin_s1_ff  <= 4'h0;
			pin_s2_ff  <= 4'h0;
			pin_s3_ff  <= 4'h0;
			pin_lvl_ff <= 4'h0;
		end else begin
			pin_s1_ff <= {drive_enable_in, genlock_strap_in, line_standard_strap_in, field_id_strap_in};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			for (int i = 0; i < 4; i++) begin
				if (pin_s2_ff[i] == pin_s3_ff[i]) begin
					pin_lvl_ff[i] <= pin_s3_ff[i];
				end
			end
		end
	end

	// Port enable also acts as the link reset, so one level crossing serves both
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			port_en_ff <= 1'b0;
		end else begin
			port_en_ff <= (pin_lvl_ff[2:0] == VHP_STRAP_HOST) && pin_lvl_ff[3];
		end
	end

	assign req_evt = req_s2_ff ^ req_seen_ff;

	// Request capture: hold word is stable while its toggle is in flight
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			req_s1_ff    <= 1'b0;
			req_s2_ff    <= 1'b0;
			req_seen_ff  <= 1'b0;
			busy_ff      <= 1'b0;
			ack_tgl_ff   <= 1'b0;
			rdata_ff     <= VHP_BYTE_RST;
			req_valid_ff <= 1'b0;
			req_ff       <= '0;
		end else begin
			req_s1_ff    <= req_tgl_ff;
			req_s2_ff    <= req_s1_ff;
			req_seen_ff  <= req_s2_ff;
			req_valid_ff <= req_evt;
			if (req_evt) begin
				req_ff  <= hold_ff;
				busy_ff <= 1'b1;
			end else if (busy_ff && rsp_valid_in) begin
				rdata_ff   <= rsp_rdata_in;
				ack_tgl_ff <= ~ack_tgl_ff;
				busy_ff    <= 1'b0;
			end
		end
	end

	// Interrupt driver; push-pull may contend if the line is shared
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			int_out_ff <= 1'b0;
			int_oe_ff  <= 1'b0;
		end else if (irq_push_pull_in) begin
			int_out_ff <= irq_in;
			int_oe_ff  <= port_en_ff;
		end else begin
			int_out_ff <= 1'b0;
			int_oe_ff  <= irq_in && port_en_ff;
		end
	end

	assign port_enabled_out             = port_en_ff;
	assign req_valid_out                = req_valid_ff;
	assign req_out                      = req_ff;
	assign interrupt_request_pin_out    = int_out_ff;
	assign interrupt_request_pin_oe_out = int_oe_ff;

	// Async clear keeps link pins quiet even while the host clock is stopped
	always_ff @(posedge host_clock_pin_in or negedge port_en_ff) begin
		if (!port_en_ff) begin
			{go_s2_ff, go_s1_ff, ack_s2_ff, ack_s1_ff} <= 4'h0;
		end else begin
			go_s1_ff  <= port_en_ff;
			go_s2_ff  <= go_s1_ff;
			ack_s1_ff <= ack_tgl_ff;
			ack_s2_ff <= ack_s1_ff;
		end
	end

	assign bus_in    = {host_bus_bit1_in, host_bus_bit0_in};
	assign byte_in   = {sh_ff, bus_in};
	assign is_rd     = cmd_ff[VHP_CMD_RD];
	// Writes ack only in the wait phase; reads ack once data is back
	assign ack_ok    = is_rd ? rd_rdy_ff : (st_ff == VHP_WAIT);
	assign launch_rd = (st_ff == VHP_DECODE) && !wr_pend_ff && is_rd;
	assign launch_wr = (st_ff == VHP_DATA) && (cnt_ff == VHP_PHASE_LAST) && !is_rd;
	assign ack_evt   = ack_s2_ff ^ ack_seen_ff;

	// Phase sequencer
	always_ff @(posedge host_clock_pin_in or negedge go_s2_ff) begin
		if (!go_s2_ff) begin
			st_ff      <= VHP_IDLE;
			cnt_ff     <= 2'h0;
			sh_ff      <= VHP_SHIFT_RST;
			cmd_ff     <= VHP_BYTE_RST;
			addr_lo_ff <= VHP_BYTE_RST;
			stop_ff    <= 1'b0;
			acked_ff   <= 1'b0;
			bus0_ff    <= 1'b0;
			bus1_ff    <= 1'b0;
			bus_oe_ff  <= 1'b0;
			ctl_oe_ff  <= 1'b0;
		end else begin
			case (st_ff)
				VHP_IDLE: begin
					if (host_control_pin_in) begin
						sh_ff  <= {4'h0, bus_in};
						cnt_ff <= 2'h1;
						st_ff  <= VHP_CMD;
					end
				end
				VHP_CMD: begin
					sh_ff  <= byte_in[5:0];
					cnt_ff <= cnt_ff + 2'h1;
					if (cnt_ff == VHP_PHASE_LAST) begin
						cmd_ff <= byte_in;
						if (byte_in[VHP_CMD_SEL_HI:VHP_CMD_SEL_LO] != VHP_DEVSEL) begin
							st_ff <= VHP_SKIP;
						end else if (byte_in[VHP_CMD_FIFO]) begin
							st_ff <= VHP_DECODE;
						end else begin
							st_ff <= VHP_ADDR;
						end
					end
				end
				VHP_ADDR: begin
					sh_ff  <= byte_in[5:0];
					cnt_ff <= cnt_ff + 2'h1;
					if (cnt_ff == VHP_PHASE_LAST) begin
						addr_lo_ff <= byte_in;
						st_ff      <= VHP_DECODE;
					end
				end
				VHP_DECODE: begin
					stop_ff   <= wr_pend_ff;
					ctl_oe_ff <= wr_pend_ff;
					cnt_ff    <= 2'h0;
					st_ff     <= VHP_RETRY;
				end
				VHP_RETRY, VHP_WAIT: begin
					cnt_ff <= cnt_ff + 2'h1;
					if (cnt_ff == VHP_CYC_STOP) begin
						ctl_oe_ff <= !stop_ff && ack_ok;
						acked_ff  <= !stop_ff && ack_ok;
					end else if (cnt_ff == VHP_CYC_ACK) begin
						ctl_oe_ff <= 1'b0;
					end
					if (cnt_ff == VHP_PHASE_LAST) begin
						if (stop_ff) begin
							st_ff <= VHP_IDLE;
						end else if (acked_ff) begin
							st_ff     <= VHP_DATA;
							bus_oe_ff <= is_rd;
							{bus1_ff, bus0_ff} <= pair_of(rdata_ff, 2'h0);
						end else begin
							st_ff     <= VHP_WAIT;
							bus_oe_ff <= is_rd;
							{bus1_ff, bus0_ff} <= 2'h0;
						end
					end
				end
				VHP_DATA: begin
					sh_ff  <= byte_in[5:0];
					cnt_ff <= cnt_ff + 2'h1;
					{bus1_ff, bus0_ff} <= pair_of(rdata_ff, cnt_ff + 2'h1);
					if (cnt_ff == VHP_PHASE_LAST) begin
						bus_oe_ff <= 1'b0;
						st_ff     <= is_rd ? VHP_TA : VHP_IDLE;
					end
				end
				VHP_TA: begin
					st_ff <= VHP_IDLE;
				end
				VHP_SKIP: begin
					if (!host_control_pin_in) begin
						st_ff <= VHP_IDLE;
					end
				end
				default: begin
					st_ff <= VHP_IDLE;
				end
			endcase
		end
	end

	// Link-side request and completion tracking
	always_ff @(posedge host_clock_pin_in or negedge go_s2_ff) begin
		if (!go_s2_ff) begin
			ack_seen_ff <= 1'b0;
			req_tgl_ff  <= 1'b0;
			hold_ff     <= '0;
			wr_pend_ff  <= 1'b0;
			rd_rdy_ff   <= 1'b0;
		end else begin
			ack_seen_ff <= ack_s2_ff;
			if (ack_evt) begin
				wr_pend_ff <= 1'b0;
				rd_rdy_ff  <= hold_ff.rd;
			end
			if (launch_rd) begin
				hold_ff    <= '{rd: 1'b1, fifo: cmd_ff[VHP_CMD_FIFO],
					addr: {cmd_ff[VHP_CMD_AHI_HI:VHP_CMD_AHI_LO], addr_lo_ff}, wdata: VHP_BYTE_RST};
				req_tgl_ff <= ~req_tgl_ff;
				rd_rdy_ff  <= 1'b0;
			end else if (launch_wr) begin
				hold_ff    <= '{rd: 1'b0, fifo: cmd_ff[VHP_CMD_FIFO],
					addr: {cmd_ff[VHP_CMD_AHI_HI:VHP_CMD_AHI_LO], addr_lo_ff}, wdata: byte_in};
				req_tgl_ff <= ~req_tgl_ff;
				wr_pend_ff <= 1'b1;
			end
		end
	end

	assign host_bus_bit0_out       = bus0_ff;
	assign host_bus_bit1_out       = bus1_ff;
	assign host_bus_oe_out         = bus_oe_ff;
	assign host_control_pin_out    = 1'b0;
	assign host_control_pin_oe_out = ctl_oe_ff;

endmodule // vhp_top

/* File: sim/vhp_monitor.sv */
// Checker for the video host port slave.
// Assumes link logic only sees clock edges while the host frames a transfer or idles four clocks before it.
`timescale 1ns/100ps
module vhp_monitor
	import vhp_pkg::*;
(
	// Clocks and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic host_clock_pin_in,
	// Straps and enable
	input wire logic genlock_strap_in,
	input wire logic line_standard_strap_in,
	input wire logic field_id_strap_in,
	input wire logic drive_enable_in,
	input wire logic port_enabled_out,
	// Link drive
	input wire logic host_bus_oe_out,
	input wire logic host_control_pin_out,
	input wire logic host_control_pin_oe_out,
	// System side
	input wire logic req_valid_out,
	input wire logic irq_in,
	input wire logic irq_push_pull_in,
	input wire logic interrupt_request_pin_out,
	input wire logic interrupt_request_pin_oe_out
);
	a_port_straps: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$rose(port_enabled_out) |-> $past(drive_enable_in) && VHP_STRAP_HOST ==
		$past({genlock_strap_in, line_standard_strap_in, field_id_strap_in})) else $error("bad enable");
	a_outputs_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!port_enabled_out && !$past(port_enabled_out) |-> !host_bus_oe_out && !host_control_pin_oe_out
		&& !interrupt_request_pin_oe_out && !req_valid_out) else $error("drive while off");
	a_irq_open_drain: assert property (@(posedge clk_in) disable iff (!nrst_in)
		port_enabled_out && $past(port_enabled_out) && !$past(irq_push_pull_in) |->
		!interrupt_request_pin_out && interrupt_request_pin_oe_out == $past(irq_in)) else $error("irq od");
	a_irq_push_pull: assert property (@(posedge clk_in) disable iff (!nrst_in)
		port_enabled_out && $past(port_enabled_out) && $past(irq_push_pull_in) |->
		interrupt_request_pin_oe_out && interrupt_request_pin_out == $past(irq_in)) else $error("irq pp");
	a_req_one_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
		req_valid_out |=> !req_valid_out) else $error("request pulse too long");
	a_req_when_on: assert property (@(posedge clk_in) disable iff (!nrst_in)
		req_valid_out |-> port_enabled_out) else $error("request while off");
	a_ctl_open_drain: assert property (@(posedge host_clock_pin_in) disable iff (!nrst_in)
		host_control_pin_oe_out |-> !host_control_pin_out) else $error("control driven high");
	a_ack_one_cycle: assert property (@(posedge host_clock_pin_in) disable iff (!nrst_in)
		host_control_pin_oe_out |=> !host_control_pin_oe_out) else $error("control held low");
	// Ack in cycle 1: two more cycles, four of data, then turnaround
	a_read_release: assert property (@(posedge host_clock_pin_in) disable iff (!nrst_in)
		host_control_pin_oe_out && host_bus_oe_out |=> host_bus_oe_out [*6] ##1 !host_bus_oe_out)
		else $error("read bus release");
	c_write_ack: cover property (@(posedge host_clock_pin_in) host_control_pin_oe_out && !host_bus_oe_out);
	c_read_ack: cover property (@(posedge host_clock_pin_in) host_control_pin_oe_out && host_bus_oe_out);
	c_port_up: cover property (@(posedge clk_in) $rose(port_enabled_out));
endmodule // vhp_monitor

bind vhp_top vhp_monitor vhp_monitor_inst (.*);

/* File: sim/vhp_host_model.sv */
// Host master model: one byte per transfer, link clock inside frames and for four idle clocks before each.
// Assumes the bench resolves the shared lines; ctl_out 1 frames a transfer.
`timescale 1ns/100ps
module vhp_host_model (
	// Link clock and master drive
	output logic       hclk_out,
	output logic       ctl_out,
	output logic       bus_oe_out,
	output logic [1:0] bus_out,
	// Resolved lines
	input wire logic       ctl_in,
	input wire logic [1:0] bus_in
);
	logic       ctl_s;
	logic [1:0] bus_s;
	initial begin
		hclk_out = 1'b0;
		ctl_out = 1'b0;
		bus_oe_out = 1'b0;
		bus_out = 2'h0;
	end
	// Sample at the edge, move 1 ns later; 12 ns period set by this task
	task automatic cyc;
		#5 hclk_out = 1'b0;
		#6 hclk_out = 1'b1;
		ctl_s = ctl_in;
		bus_s = bus_in;
		#1;
	endtask
	task automatic send(input logic [7:0] b);
		for (int i = 3; i >= 0; i--) begin
			bus_out = b[2*i +: 2];
			cyc();
		end
	endtask
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] wd,
		input int maxph, output logic [7:0] rd, output int nph, output logic stop);
		logic ack;
		rd = 8'h00;
		nph = 0;
		ack = 1'b0;
		repeat (4) cyc();
		ctl_out = 1'b1;
		bus_oe_out = 1'b1;
		send(cmd);
		if (!cmd[4]) send(adr);
		bus_oe_out = !cmd[5];
		bus_out = wd[7:6];
		cyc();
		do begin
			nph++;
			cyc();
			stop = !ctl_s && nph == 1;
			cyc();
			ack = !ctl_s && !stop;
			cyc();
			cyc();
		end while (!stop && !ack && nph < maxph);
		if (ack && cmd[5]) begin
			bus_oe_out = 1'b0;
			repeat (4) begin
				cyc();
				rd = {rd[5:0], bus_s};
			end
			cyc();
		end else if (ack) send(wd);
		ctl_out = 1'b0;
		bus_oe_out = 1'b0;
	endtask
endmodule // vhp_host_model

/* File: sim/vhp_top_tb.sv */
// Bench for the video host port slave: host model on the link, responder on the system side.
// Assumes the checker binds itself to the top module.
`timescale 1ns/100ps
module vhp_top_tb
	import vhp_pkg::*;
;
	logic clk_in = 1'b0, nrst_in = 1'b0, drive_enable_in = 1'b1, rsp_valid_in = 1'b0;
	logic genlock_strap_in = 1'b0, line_standard_strap_in = 1'b1, field_id_strap_in = 1'b0;
	logic irq_in = 1'b0, irq_push_pull_in = 1'b0, tog = 1'b0, stop, m_ctl, m_oe;
	logic [7:0] rsp_rdata_in = 8'h00, rd;
	logic [1:0] m_bus;
	logic port_enabled_out, host_bus_bit0_out, host_bus_bit1_out, host_bus_oe_out, req_valid_out;
	logic host_control_pin_out, host_control_pin_oe_out, interrupt_request_pin_out, interrupt_request_pin_oe_out;
	vhp_req_t req_out;
	wire logic host_clock_pin_in, host_bus_bit0_in, host_bus_bit1_in, host_control_pin_in;
	int err_count = 0, compares = 0, nreq = 0, rsp_delay = 2, nph;
	always #50 clk_in = ~clk_in;
	always @(posedge host_clock_pin_in) tog <= ~tog;
	// Host level wins unless the slave pulls low; a released bus keeps changing
	assign host_control_pin_in = (host_control_pin_oe_out === 1'b1) ? 1'b0 : m_ctl;
	assign {host_bus_bit1_in, host_bus_bit0_in} = (host_bus_oe_out === 1'b1) ?
		{host_bus_bit1_out, host_bus_bit0_out} : m_oe ? m_bus : {tog, ~tog};
	vhp_top vhp_top_inst (.*);
	vhp_host_model vhp_host_model_inst (.hclk_out(host_clock_pin_in), .ctl_out(m_ctl), .bus_oe_out(m_oe),
		.bus_out(m_bus), .ctl_in(host_control_pin_in), .bus_in({host_bus_bit1_in, host_bus_bit0_in}));
	initial forever begin
		@(negedge clk_in);
		if (req_valid_out === 1'b1) begin
			nreq++;
			repeat (rsp_delay) @(negedge clk_in);
			rsp_valid_in = 1'b1;
			@(negedge clk_in);
			rsp_valid_in = 1'b0;
		end
	end
	task automatic check(input logic [21:0] seen, input logic [21:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (err_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wait_req(input int n0);
		for (int i = 0; i < 20 && nreq == n0; i++) @(negedge clk_in);
		check(22'(nreq), 22'(n0 + 1));
		if (nreq == n0) end_of_test();
	endtask
	task automatic t_straps;
		for (int s = 0; s < 9; s++) begin
			{genlock_strap_in, line_standard_strap_in, field_id_strap_in} = (s == 8) ? 3'h2 : 3'(s);
			drive_enable_in = (s != 8);
			repeat (10) @(negedge clk_in);
			check(port_enabled_out, s == 2);
		end
		drive_enable_in = 1'b1;
		repeat (10) @(negedge clk_in);
	endtask
	task automatic t_irq;
		for (int i = 0; i < 4; i++) begin
			{irq_push_pull_in, irq_in} = 2'(i);
			repeat (3) @(negedge clk_in);
			check({interrupt_request_pin_oe_out, interrupt_request_pin_out}, i[1] ? {1'b1, i[0]} : {i[0], 1'b0});
		end
		irq_in = 1'b0;
	endtask
	// Slow answer keeps the write pending while the next access arrives
	task automatic t_write;
		int n0;
		n0 = nreq;
		rsp_delay = 40;
		vhp_host_model_inst.xfer(8'h41, 8'h5A, 8'hC3, 8, rd, nph, stop);
		check({stop, 4'(nph)}, {1'b0, 4'h2});
		wait_req(n0);
		check(req_out, {1'b0, 1'b0, 12'h15A, 8'hC3});
		vhp_host_model_inst.xfer(8'h61, 8'h23, 8'h00, 8, rd, nph, stop);
		check({stop, 4'(nph)}, {1'b1, 4'h1});
		check(22'(nreq), 22'(n0 + 1));
		repeat (50) @(negedge clk_in);
		rsp_delay = 3;
	endtask
	task automatic t_read(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] dat);
		int n0;
		n0 = nreq;
		rsp_rdata_in = dat;
		vhp_host_model_inst.xfer(cmd, adr, 8'h00, 40, rd, nph, stop);
		check({stop, rd}, {1'b0, dat});
		check(host_bus_oe_out, 1'b0);
		wait_req(n0);
		check(req_out[21:16], {1'b1, cmd[4], cmd[3:0]});
		if (!cmd[4]) check(req_out[15:8], adr);
	endtask
	task automatic t_baddev;
		int n0;
		n0 = nreq;
		vhp_host_model_inst.xfer(8'hC1, 8'h10, 8'h00, 2, rd, nph, stop);
		check({stop, 4'(nph)}, {1'b0, 4'h2});
		repeat (5) @(negedge clk_in);
		check(22'(nreq), 22'(n0));
	endtask
	initial begin
		repeat (6) @(negedge clk_in);
		nrst_in = 1'b1;
		t_straps();
		t_irq();
		t_write();
		t_read(8'h61, 8'h23, 8'hA5);
		t_read(8'h74, 8'h00, 8'h3C);
		t_baddev();
		t_read(8'h60, 8'hF0, 8'h5A);
		end_of_test();
	end
endmodule // vhp_top_tb
